// ### rtl/ovs_mem_if.sv
// Carrier between the setpoint bank and its word storage.
// Assumes one clock shared by both ends.
interface ovs_mem_if #(
    parameter int NUM_WORDS = 10,
    parameter int AW        = 4
);
    logic        we;
    logic [AW-1:0] wrAddr;
    logic [15:0] wrData;
    logic [AW-1:0] rdAddr;
    logic [15:0] rdData;
    logic [15:0] words [NUM_WORDS];

    modport owner (input we, wrAddr, wrData, rdAddr,
                   output rdData, words);
    modport user  (output we, wrAddr, wrData, rdAddr,
                   input rdData, words);
endinterface

// ### rtl/ovs_pkg.sv
// Types and helpers of the output voltage setpoint register bank.
// Assumes the constants header is on the include path.
`include "ovs_setpoint_regs.svh"

package ovs_pkg;

    // ======================================================================
    // Types.
    typedef enum logic [1:0] {
        SRC_NOMINAL     = 2'b00,
        SRC_MARGIN_LOW  = 2'b01,
        SRC_MARGIN_HIGH = 2'b10,
        SRC_UNUSED      = 2'b11
    } ovs_src_e;

    typedef enum logic [2:0] {
        IDX_TRIM    = 3'b000,
        IDX_CEILING = 3'b001,
        IDX_MHIGH   = 3'b010,
        IDX_MLOW    = 3'b011,
        IDX_RATE    = 3'b100,
        IDX_NONE    = 3'b111
    } ovs_idx_e;

    // ======================================================================
    // Helpers.
    function automatic ovs_idx_e ovsDecode(input logic [7:0] code);
        if (code == `OVS_CMD_TRIM) begin
            return IDX_TRIM;
        end else if (code == `OVS_CMD_CEILING) begin
            return IDX_CEILING;
        end else if (code == `OVS_CMD_MARGIN_HIGH) begin
            return IDX_MHIGH;
        end else if (code == `OVS_CMD_MARGIN_LOW) begin
            return IDX_MLOW;
        end else if (code == `OVS_CMD_SLEW_RATE) begin
            return IDX_RATE;
        end else begin
            return IDX_NONE;
        end
    endfunction

    function automatic logic [15:0] ovsResetOf(input int idx);
        case (idx)
            0:       return `OVS_RST_TRIM;
            1:       return `OVS_RST_CEILING;
            2:       return `OVS_RST_MARGIN_HIGH;
            3:       return `OVS_RST_MARGIN_LOW;
            default: return `OVS_RST_SLEW_RATE;
        endcase
    endfunction

endpackage

// ### rtl/ovs_setpoint_bank.sv
// Output voltage setpoint bank: per-page trim, ceiling, margins, slew rate.
// Assumes the command decoder and context inputs run on ref_clk.
`include "ovs_setpoint_regs.svh"

module ovs_setpoint_bank
    import ovs_pkg::*;
#(
    parameter int NUM_PAGES = 2,
    parameter int PAGE_W    = 1
) (
    // Clock and reset.
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    // Command port from the link decoder.
    input  wire logic               cmdValid,
    input  wire logic               cmdWrite,
    input  wire logic [7:0]         cmdCode,
    input  wire logic [PAGE_W-1:0]  cmdPage,
    input  wire logic [15:0]        cmdData,
    // Read answer and refusal.
    output logic                    rdValid,
    output logic [15:0]             rdData,
    output logic                    cmdRefused,
    // Context from the neighbouring command logic.
    input  wire logic [7:0]         writeProtect,
    input  wire logic [1:0]         voutSource [NUM_PAGES],
    input  wire logic [15:0]        nominalCmd [NUM_PAGES],
    // Regulated target per page, in 100 uV units.
    output logic [17:0]             voutTarget [NUM_PAGES],
    output logic                    rampActive [NUM_PAGES]
);

    localparam int NUM_WORDS = NUM_PAGES * `OVS_NUM_REGS;
    localparam int AW        = $clog2(NUM_WORDS);
    localparam int TICK_CYC  = `OVS_SLEW_TICK_CYC;

    ovs_mem_if #(.NUM_WORDS(NUM_WORDS), .AW(AW)) mem ();

    ovs_setpoint_mem #(.NUM_WORDS(NUM_WORDS)) u_mem (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .mem     (mem.owner)
    );

    function automatic logic [AW-1:0] wordAddr(input int page, input int idx);
        return AW'(page * `OVS_NUM_REGS + idx);
    endfunction

    function automatic logic [17:0] toTenths(input logic [17:0] mv);
        return (mv << 3) + (mv << 1);
    endfunction

    // ======================================================================
    // Command decode and write admission.
    ovs_idx_e    cmdIdx;
    logic        pageOk;
    logic        rangeOk;
    logic        protectOk;
    logic        regWrite;
    logic        commitCmd;

    always_comb begin
        cmdIdx    = ovsDecode(cmdCode);
        pageOk    = int'(cmdPage) < NUM_PAGES;
        rangeOk   = 1'b1;
        if (cmdIdx == IDX_TRIM) begin
            rangeOk = ($signed(cmdData) <= `OVS_TRIM_LIMIT_MV) &&
                      ($signed(cmdData) >= -`OVS_TRIM_LIMIT_MV);
        end else if (cmdIdx == IDX_CEILING) begin
            rangeOk = cmdData <= `OVS_CEILING_MAX_MV;
        end
        if (writeProtect == `OVS_WP_OPEN) begin
            protectOk = 1'b1;
        end else if (writeProtect == `OVS_WP_TRIM_ONLY) begin
            protectOk = cmdIdx == IDX_TRIM;
        end else begin
            protectOk = 1'b0;
        end
        regWrite  = cmdValid && cmdWrite && cmdIdx != IDX_NONE && pageOk;
        commitCmd = cmdValid && cmdWrite && cmdCode == `OVS_CMD_COMMIT &&
                    pageOk;
    end

    assign mem.we     = regWrite && protectOk && rangeOk;
    assign mem.wrAddr = wordAddr(int'(cmdPage), int'(cmdIdx));
    assign mem.wrData = cmdData;
    assign mem.rdAddr = wordAddr(int'(cmdPage), int'(cmdIdx));
    assign rdData     = mem.rdData;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdValid    <= 1'b0;
            cmdRefused <= 1'b0;
        end else begin
            rdValid    <= cmdValid && !cmdWrite && cmdIdx != IDX_NONE &&
                          pageOk;
            cmdRefused <= regWrite && !(protectOk && rangeOk);
        end
    end

    // ======================================================================
    // Active slew rate, taken over only on the commit command.
    logic [15:0] activeRate [NUM_PAGES];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int p = 0; p < NUM_PAGES; p++) begin
                activeRate[p] <= `OVS_RST_SLEW_RATE;
            end
        end else if (commitCmd) begin
            activeRate[cmdPage] <=
                mem.words[wordAddr(int'(cmdPage), int'(IDX_RATE))];
        end
    end

    // ======================================================================
    // Goal per page: selected setpoint plus trim, held under the ceiling.
    logic [17:0] goalT  [NUM_PAGES];
    logic [17:0] ceilT  [NUM_PAGES];

    always_comb begin
        logic signed [17:0] sel;
        logic signed [17:0] trim;
        logic signed [17:0] ceil;
        logic signed [17:0] sum;
        sel  = '0;
        trim = '0;
        ceil = '0;
        sum  = '0;
        for (int p = 0; p < NUM_PAGES; p++) begin
            case (voutSource[p])
                SRC_MARGIN_LOW:
                    sel = 18'($signed(
                        mem.words[wordAddr(p, int'(IDX_MLOW))]));
                SRC_MARGIN_HIGH:
                    sel = 18'($signed(
                        mem.words[wordAddr(p, int'(IDX_MHIGH))]));
                default:
                    sel = 18'($signed(nominalCmd[p]));
            endcase
            trim = 18'($signed(mem.words[wordAddr(p, int'(IDX_TRIM))]));
            ceil = 18'($signed(mem.words[wordAddr(p, int'(IDX_CEILING))]));
            sum  = sel + trim;
            if (ceil < 0) begin
                ceil = '0;
            end
            if (sum > ceil) begin
                sum = ceil;
            end
            if (sum < 0) begin
                sum = '0;
            end
            goalT[p] = toTenths(sum);
            ceilT[p] = toTenths(ceil);
        end
    end

    // ======================================================================
    // Microsecond tick for slewing.
    logic [$clog2(TICK_CYC)-1:0] tickCnt;
    logic                        slewTick;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt <= '0;
        end else if (slewTick) begin
            tickCnt <= '0;
        end else begin
            tickCnt <= tickCnt + 1'b1;
        end
    end

    assign slewTick = tickCnt == ($clog2(TICK_CYC))'(TICK_CYC - 1);

    // ======================================================================
    // Slewed target: rate counts of 100 uV per microsecond tick.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int p = 0; p < NUM_PAGES; p++) begin
                voutTarget[p] <= '0;
                rampActive[p] <= 1'b0;
            end
        end else begin
            for (int p = 0; p < NUM_PAGES; p++) begin
                rampActive[p] <= voutTarget[p] != goalT[p];
                if (voutTarget[p] > ceilT[p]) begin
                    voutTarget[p] <= ceilT[p];
                end else if (slewTick) begin
                    if (goalT[p] > voutTarget[p] + activeRate[p]) begin
                        voutTarget[p] <= voutTarget[p] + activeRate[p];
                    end else if (voutTarget[p] > goalT[p] + activeRate[p])
                    begin
                        voutTarget[p] <= voutTarget[p] - activeRate[p];
                    end else begin
                        voutTarget[p] <= goalT[p];
                    end
                end
            end
        end
    end

    // ======================================================================
    // Checks.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_locked_refuses;
        cmdValid && cmdWrite && writeProtect == 8'h40 &&
        cmdIdx != IDX_NONE && pageOk |=> cmdRefused;
    endproperty
    a_locked_refuses: assert property (p_locked_refuses)
        else $error("write accepted under full protection");

    property p_trim_passes;
        cmdValid && cmdWrite && writeProtect == 8'h20 &&
        cmdIdx == IDX_TRIM && rangeOk && pageOk |=> !cmdRefused;
    endproperty
    a_trim_passes: assert property (p_trim_passes)
        else $error("trim write refused at level 20h");

    property p_under_ceiling;
        1'b1 |=> voutTarget[0] <= $past(ceilT[0]);
    endproperty
    a_under_ceiling: assert property (p_under_ceiling)
        else $error("target above ceiling");

    property p_goal_ceiling;
        goalT[0] <= ceilT[0];
    endproperty
    a_goal_ceiling: assert property (p_goal_ceiling)
        else $error("goal above ceiling");

    property p_rate_holds;
        !commitCmd |=> $stable(activeRate[0]);
    endproperty
    a_rate_holds: assert property (p_rate_holds)
        else $error("rate changed without commit");

    property p_rate_commit;
        commitCmd && cmdPage == '0 |=>
        activeRate[0] == $past(mem.words[wordAddr(0, 4)]);
    endproperty
    a_rate_commit: assert property (p_rate_commit)
        else $error("commit did not take pending rate");

    property p_slew_still;
        !slewTick && voutTarget[0] <= ceilT[0] ##1 voutTarget[0] <= ceilT[0]
        |-> $stable(voutTarget[0]);
    endproperty
    a_slew_still: assert property (p_slew_still)
        else $error("target moved between ticks");

    property p_tick_period;
        slewTick |=> !slewTick [*8];
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("slew tick too frequent");

    property p_margin_high;
        voutSource[0] == 2'b10 && mem.words[0] == 16'h0000 &&
        !mem.words[2][15] && mem.words[2] <= mem.words[1]
        |-> goalT[0] == toTenths(18'(mem.words[2]));
    endproperty
    a_margin_high: assert property (p_margin_high)
        else $error("margin-high goal wrong");

    property p_margin_low;
        voutSource[0] == 2'b01 && mem.words[0] == 16'h0000 &&
        !mem.words[3][15] && mem.words[3] <= mem.words[1]
        |-> goalT[0] == toTenths(18'(mem.words[3]));
    endproperty
    a_margin_low: assert property (p_margin_low)
        else $error("margin-low goal wrong");

    property p_page_apart;
        mem.we && mem.wrAddr >= AW'(`OVS_NUM_REGS) |=>
        $stable(mem.words[0]) && $stable(mem.words[4]);
    endproperty
    a_page_apart: assert property (p_page_apart)
        else $error("write to page 1 touched page 0");

    c_trim_write: cover property (mem.we && cmdIdx == IDX_TRIM);
    c_commit:     cover property (commitCmd);
    c_refused:    cover property (cmdRefused);
    c_ramp_done:  cover property (rampActive[0] ##1 !rampActive[0]);

endmodule

// ### rtl/ovs_setpoint_mem.sv
// Word storage for all setpoint registers of all pages.
// Assumes word address = page * register count + register index.
`include "ovs_setpoint_regs.svh"

module ovs_setpoint_mem
    import ovs_pkg::*;
#(
    parameter int NUM_WORDS = 10
) (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Storage port.
    ovs_mem_if.owner  mem
);

    // ======================================================================
    // Storage, each word reset to its register's default.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                mem.words[i] <= ovsResetOf(i % `OVS_NUM_REGS);
            end
        end else if (mem.we) begin
            mem.words[mem.wrAddr] <= mem.wrData;
        end
    end

    // ======================================================================
    // Registered read port.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem.rdData <= 16'h0000;
        end else if (int'(mem.rdAddr) < NUM_WORDS) begin
            mem.rdData <= mem.words[mem.rdAddr];
        end
    end

endmodule

// ### rtl/ovs_setpoint_regs.svh
// Constants of the output voltage setpoint register bank.
// Assumes a command decoder in front that hands over whole 16-bit words.
// How it works
// - signed trim adds to target, zero reset, +-250mV
// - target cut to ceiling one cycle after ceiling drops below it; ceiling 0..3300mV
// - margin-high source uses margin-high register value
// - margin-low source uses margin-low register value
// - slew target at rate counts of 100uV/us
// - new rate waits for commit command
// - separate 16-bit copy per output page
// - source code 00 nominal, 01 low, 10 high
// - protection level 20h still admits trim writes
`ifndef OVS_SETPOINT_REGS_SVH
`define OVS_SETPOINT_REGS_SVH

// ==========================================================================
// Command codes.
`define OVS_CMD_TRIM         8'h22
`define OVS_CMD_CEILING      8'h24
`define OVS_CMD_MARGIN_HIGH  8'h25
`define OVS_CMD_MARGIN_LOW   8'h26
`define OVS_CMD_SLEW_RATE    8'h27
`define OVS_CMD_COMMIT       8'he7

// ==========================================================================
// Reset values.
`define OVS_RST_TRIM         16'h0000
`define OVS_RST_CEILING      16'h08fc
`define OVS_RST_MARGIN_HIGH  16'h0640
`define OVS_RST_MARGIN_LOW   16'h00fa
`define OVS_RST_SLEW_RATE    16'h0064

// ==========================================================================
// Write protection levels and value ranges.
`define OVS_WP_OPEN          8'h00
`define OVS_WP_TRIM_ONLY     8'h20
`define OVS_TRIM_LIMIT_MV    16'sh00fa
`define OVS_CEILING_MAX_MV   16'h0ce4

// ==========================================================================
// Slew timing: one slew step per microsecond.
`define OVS_CLK_PERIOD_NS    50
`define OVS_SLEW_TICK_NS     1000
`define OVS_SLEW_TICK_CYC    (`OVS_SLEW_TICK_NS / `OVS_CLK_PERIOD_NS)
`define OVS_NUM_REGS         5

`endif

// ### testbench/output_voltage_setpoint_regs_tb_top.sv
// Self-checking bench of the output voltage setpoint bank.
// Assumes the host model drives the command port; context comes from here.
module output_voltage_setpoint_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk;
    logic        rst_n;
    logic        cmdValid;
    logic        cmdWrite;
    logic [7:0]  cmdCode;
    logic [0:0]  cmdPage;
    logic [15:0] cmdData;
    logic        rdValid;
    logic [15:0] rdData;
    logic        cmdRefused;
    logic [7:0]  writeProtect;
    logic [1:0]  voutSource [2];
    logic [15:0] nominalCmd [2];
    logic [17:0] voutTarget [2];
    logic        rampActive [2];
    int          n_errors;
    int          n_compared;

    ovs_host_model host (.ref_clk(ref_clk), .cmdValid(cmdValid),
        .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdPage(cmdPage),
        .cmdData(cmdData), .rdValid(rdValid), .rdData(rdData),
        .cmdRefused(cmdRefused));

    ovs_setpoint_bank #(.NUM_PAGES(2), .PAGE_W(1)) DUT (.ref_clk(ref_clk),
        .rst_n(rst_n), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
        .cmdCode(cmdCode), .cmdPage(cmdPage), .cmdData(cmdData),
        .rdValid(rdValid), .rdData(rdData), .cmdRefused(cmdRefused),
        .writeProtect(writeProtect), .voutSource(voutSource),
        .nominalCmd(nominalCmd), .voutTarget(voutTarget),
        .rampActive(rampActive));

    // ======================================================================
    // Shared checks and bus cycles.
    task automatic cmp(input logic [17:0] got, input logic [17:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected at %0t: %s got %h want %h",
                     $time, what, got, exp);
            n_errors++;
        end
    endtask

    task automatic wr(input logic [7:0] code, input logic [0:0] page,
                      input logic [15:0] data, input logic refused);
        logic        a;
        logic [15:0] v;
        host.issue(1'b1, code, page, data, a, v);
        cmp({17'h0, a}, {17'h0, refused}, "write refusal");
    endtask

    task automatic rd(input logic [7:0] code, input logic [0:0] page,
                      input logic [15:0] exp);
        logic        a;
        logic [15:0] v;
        host.issue(1'b0, code, page, 16'h0000, a, v);
        cmp({17'h0, a}, 18'h00001, "read answer");
        cmp({2'h0, v}, {2'h0, exp}, "read data");
    endtask

    task automatic src(input logic [1:0] s);
        @(posedge ref_clk);
        voutSource[0] <= s;
    endtask

    task automatic settle(input logic [17:0] exp);
        for (int i = 0; i < 8000; i++) begin
            @(posedge ref_clk);
            #1;
            if (voutTarget[0] === exp && rampActive[0] === 1'b0) break;
        end
        cmp(voutTarget[0], exp, "settled target");
        cmp({17'h0, rampActive[0]}, 18'h00000, "ramp flag");
    endtask

    task automatic step(input logic [17:0] exp);
        logic [17:0] v [3];
        v[0] = voutTarget[0];
        for (int k = 1; k < 3; k++) begin
            for (int i = 0; i < 40 && voutTarget[0] === v[k-1]; i++)
                @(posedge ref_clk);
            #1;
            v[k] = voutTarget[0];
        end
        cmp(v[2] - v[1], exp, "slew step");
    endtask

    // ======================================================================
    // Scenarios.
    task automatic test_reset();
        logic [7:0]  codes [5] = '{8'h22, 8'h24, 8'h25, 8'h26, 8'h27};
        logic [15:0] vals  [5] = '{16'h0000, 16'h08fc, 16'h0640,
                                   16'h00fa, 16'h0064};
        for (int p = 0; p < 2; p++)
            for (int r = 0; r < 5; r++)
                rd(codes[r], p[0:0], vals[r]);
    endtask

    task automatic test_ranges();
        wr(8'h22, 1'b0, 16'h00fa, 1'b0);
        wr(8'h22, 1'b0, 16'h00fb, 1'b1);
        rd(8'h22, 1'b0, 16'h00fa);
        wr(8'h22, 1'b0, 16'hff06, 1'b0);
        wr(8'h22, 1'b0, 16'hff05, 1'b1);
        wr(8'h24, 1'b0, 16'h0ce4, 1'b0);
        wr(8'h24, 1'b0, 16'h0ce5, 1'b1);
        wr(8'h24, 1'b0, 16'hffff, 1'b1);
        rd(8'h24, 1'b0, 16'h0ce4);
        wr(8'h24, 1'b0, 16'h08fc, 1'b0);
        wr(8'h22, 1'b0, 16'h0000, 1'b0);
    endtask

    task automatic test_pages();
        logic        a;
        logic [15:0] v;
        wr(8'h25, 1'b1, 16'h0700, 1'b0);
        rd(8'h25, 1'b0, 16'h0640);
        rd(8'h25, 1'b1, 16'h0700);
        host.issue(1'b0, 8'h30, 1'b0, 16'h0000, a, v);
        cmp({17'h0, a}, 18'h00000, "unknown code answered");
    endtask

    task automatic test_protect();
        @(posedge ref_clk);
        writeProtect <= 8'h20;
        wr(8'h22, 1'b0, 16'h0005, 1'b0);
        wr(8'h26, 1'b0, 16'h0100, 1'b1);
        rd(8'h26, 1'b0, 16'h00fa);
        rd(8'h22, 1'b0, 16'h0005);
        @(posedge ref_clk);
        writeProtect <= 8'h40;
        wr(8'h22, 1'b0, 16'h0006, 1'b1);
        @(posedge ref_clk);
        writeProtect <= 8'h00;
        wr(8'h22, 1'b0, 16'h0000, 1'b0);
    endtask

    task automatic test_target();
        src(2'b10);
        settle(18'd16000);
        src(2'b01);
        settle(18'd2500);
        src(2'b00);
        wr(8'h22, 1'b0, 16'h0064, 1'b0);
        settle(18'd10000);
        src(2'b11);
        settle(18'd10000);
        @(posedge ref_clk);
        nominalCmd[0] <= 16'h0bb8;
        settle(18'd23000);
        wr(8'h24, 1'b0, 16'h0800, 1'b0);
        @(posedge ref_clk);
        #1;
        cmp(voutTarget[0], 18'd20480, "ceiling cut");
        wr(8'h24, 1'b0, 16'h08fc, 1'b0);
        wr(8'h22, 1'b0, 16'h0000, 1'b0);
        @(posedge ref_clk);
        nominalCmd[0] <= 16'h0384;
    endtask

    task automatic test_slew();
        src(2'b01);
        settle(18'd2500);
        src(2'b10);
        step(18'd100);
        wr(8'h27, 1'b0, 16'h00c8, 1'b0);
        rd(8'h27, 1'b0, 16'h00c8);
        step(18'd100);
        host.commit(1'b0);
        step(18'd200);
        cmp(voutTarget[1], 18'd9000, "page 1 target");
        cmp({17'h0, rampActive[1]}, 18'h00000, "page 1 ramp");
    endtask

    // ======================================================================
    // Run control.
    task automatic wrap_up();
        $display("errors %0d, comparisons %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        #2000000;
        n_errors++;
        wrap_up();
    end

    initial begin
        n_errors      = 0;
        n_compared    = 0;
        rst_n         = 1'b0;
        writeProtect  = 8'h00;
        voutSource[0] = 2'b00;
        voutSource[1] = 2'b00;
        nominalCmd[0] = 16'h0384;
        nominalCmd[1] = 16'h0384;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        test_reset();
        test_ranges();
        test_pages();
        test_protect();
        test_target();
        test_slew();
        wrap_up();
    end
endmodule

// ### testbench/ovs_host_model.sv
// Host side of the setpoint bank command port: issues whole 16-bit words.
// Assumes the bank takes a command at the rising edge with cmdValid high.
module ovs_host_model (
    // Clock.
    input  wire logic        ref_clk,
    // Command port toward the bank.
    output logic             cmdValid,
    output logic             cmdWrite,
    output logic [7:0]       cmdCode,
    output logic [0:0]       cmdPage,
    output logic [15:0]      cmdData,
    // Answers from the bank.
    input  wire logic        rdValid,
    input  wire logic [15:0] rdData,
    input  wire logic        cmdRefused
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cmdValid = 1'b0;
        cmdWrite = 1'b0;
        cmdCode  = 8'h00;
        cmdPage  = 1'b0;
        cmdData  = 16'h0000;
    end

    // ======================================================================
    // One command; ans is the refusal flag of a write or rdValid of a read.
    task automatic issue(input logic wr, input logic [7:0] code,
                         input logic [0:0] page, input logic [15:0] data,
                         output logic ans, output logic [15:0] value);
        @(posedge ref_clk);
        cmdValid <= 1'b1;
        cmdWrite <= wr;
        cmdCode  <= code;
        cmdPage  <= page;
        cmdData  <= data;
        @(posedge ref_clk);
        // Released code and data lines show the inverse so no stale word looks valid.
        cmdValid <= 1'b0;
        cmdCode  <= ~code;
        cmdData  <= ~data;
        #1;
        ans   = wr ? cmdRefused : rdValid;
        value = rdData;
    endtask

    // ======================================================================
    // A pending slew rate only applies once the host commits it.
    task automatic commit(input logic [0:0] page);
        logic        a;
        logic [15:0] v;
        issue(1'b1, 8'he7, page, 16'h0000, a, v);
    endtask
endmodule
